// File: hdl/eeload_pkg.sv
`default_nettype none
package eeload_pkg;

   // image layout of the configuration storage
   localparam logic [7:0] SIG_VALUE   = 8'hA5;   // programmed-image marker
   localparam logic [7:0] SIG_ADDR    = 8'h00;   // marker byte address
   localparam logic [7:0] MAC_FIRST   = 8'h01;   // first station address octet
   localparam logic [7:0] MAC_LAST    = 8'h06;   // last station address octet
   localparam logic [7:0] FS_ADDR     = 8'h07;   // full-speed polling interval
   localparam logic [7:0] HS_ADDR     = 8'h08;   // high-speed polling interval
   localparam logic [7:0] CFG0_ADDR   = 8'h09;   // first configuration flag byte
   localparam logic [7:0] LANG_LO     = 8'h0A;   // language id low byte
   localparam logic [7:0] LANG_HI     = 8'h0B;   // language id high byte
   localparam logic [7:0] STR_BASE    = 8'h0C;   // first length/pointer pair
   localparam int         STR_COUNT   = 4;       // manufacturer, product, serial, config
   localparam logic [7:0] IMG_LAST    = 8'h13;   // last byte of the header image
   localparam int         IMG_DEPTH   = 20;      // bytes 00h..13h kept locally
   localparam logic [7:0] WAKE_ADDR   = 8'h20;   // power/wake flag byte

   // power/wake flag byte fields
   localparam int WAKE_DA_BIT    = 0;            // destination match enable
   localparam int WAKE_MAGIC_BIT = 1;            // magic packet enable
   localparam int WAKE_SEL_BIT   = 2;            // 0 = wake events, 1 = link-up

   // built-in defaults when no programmed image is found
   localparam logic [7:0] DEF_MAC_BYTE = 8'hFF;
   localparam logic [7:0] DEF_FS       = 8'h01;
   localparam logic [7:0] DEF_HS       = 8'h04;
   localparam logic [7:0] DEF_CFG0     = 8'h1B;
   localparam logic [7:0] DEF_OTHER    = 8'h00;  // language, strings, wake byte

   // register map of the plain register port
   localparam logic [7:0] REG_CTRL     = 8'h00;  // bit0 write 1 = soft reload
   localparam logic [7:0] REG_STATUS   = 8'h04;  // ready, programmed, busy
   localparam logic [7:0] REG_MAC_HI   = 8'h08;  // station address octets 1..4
   localparam logic [7:0] REG_MAC_LO   = 8'h0C;  // station address octets 5..6
   localparam logic [7:0] REG_WAKE     = 8'h10;  // raw wake flag byte
   localparam int CTRL_SOFT_BIT  = 0;
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_PROG_BIT  = 1;
   localparam int STAT_BUSY_BIT  = 2;

   // decoded configuration handed to the usb core
   typedef struct packed {
      logic [47:0] mac;
      logic [7:0]  fs_interval;
      logic [7:0]  hs_interval;
      logic [7:0]  cfg_flags0;
      logic [15:0] lang_id;
   } usb_cfg_t;

   // one string descriptor: length and byte address
   typedef struct packed {
      logic [7:0] len;
      logic [8:0] byte_addr;
   } str_desc_t;

   // decoded wake selections
   typedef struct packed {
      logic wake_source_select;
      logic magic_wake_enable;
      logic dest_match_wake_enable;
   } wake_cfg_t;

   // byte read request toward the eeprom controller
   typedef struct packed {
      logic       req;
      logic [7:0] addr;
   } ee_req_t;

   // loader sequencer states
   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_ISSUE = 3'b010,
      S_WAIT  = 3'b100
   } load_state_t;

endpackage
`default_nettype wire

// File: hdl/ee_byte_fetch.sv
`timescale 1ns/10ps
`default_nettype none
module ee_byte_fetch (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               ce,
   // loader side
   input  wire logic               start,
   input  wire logic [7:0]         addr,
   output logic                    done,
   output logic [7:0]              data,
   // eeprom controller side
   output eeload_pkg::ee_req_t     ee_req,
   input  wire logic               ee_ack,
   input  wire logic [7:0]         ee_data
);
   import eeload_pkg::*;

   // request stays up until the controller acknowledges it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ee_req <= '0;
      end else if (ce) begin
         if (start && !ee_req.req) begin
            ee_req.req  <= 1'b1;
            ee_req.addr <= addr;
         end else if (ee_req.req && ee_ack) begin
            ee_req.req <= 1'b0;
         end
      end
   end

   // capture the byte and flag completion one cycle after the ack
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data <= 8'h00;
         done <= 1'b0;
      end else if (ce) begin
         done <= ee_req.req && ee_ack;
         if (ee_req.req && ee_ack) begin
            data <= ee_data;
         end
      end
   end
endmodule // ee_byte_fetch
`default_nettype wire

// File: hdl/serial_eeprom_autoload.sv
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_autoload (
   // clock, reset, clock enable
   input  wire logic                                     CLK,
   input  wire logic                                     RST_B,
   input  wire logic                                     CE,
   // reload triggers
   input  wire logic                                     USB_BUS_RESET,
   input  wire logic                                     EXTERNAL_RESET_PIN_B,
   // register port
   input  wire logic [7:0]                               REG_ADDR,
   input  wire logic [31:0]                              REG_WDATA,
   input  wire logic                                     REG_WR,
   input  wire logic                                     REG_RD,
   output logic [31:0]                                   REG_RDATA,
   // eeprom controller
   output eeload_pkg::ee_req_t                           EE_REQ,
   input  wire logic                                     EE_ACK,
   input  wire logic [7:0]                               EE_DATA,
   // configuration consumers
   output eeload_pkg::usb_cfg_t                          USB_CFG,
   output eeload_pkg::str_desc_t [eeload_pkg::STR_COUNT-1:0] STR_DESC,
   output eeload_pkg::wake_cfg_t                         WAKE_CFG,
   output logic                                          CONFIG_READY
);
   import eeload_pkg::*;
   // local image copy feeds every consumer
   // half full loads hide behind low ready

   // default content of one header image byte
   // built-in values
   function automatic logic [7:0] default_byte(input int idx);
      logic [7:0] b;
      b = DEF_OTHER;
      if (idx >= int'(MAC_FIRST) && idx <= int'(MAC_LAST)) begin
         b = DEF_MAC_BYTE;
      end else if (idx == int'(FS_ADDR)) begin
         b = DEF_FS;
      end else if (idx == int'(HS_ADDR)) begin
         b = DEF_HS;
      end else if (idx == int'(CFG0_ADDR)) begin
         b = DEF_CFG0;
      end
      return b;
   endfunction

   // sequencer bookkeeping
   load_state_t state;                 // sequencer state
   logic [7:0]  cur_addr;              // byte being fetched
   // pending requests
   logic        mode_full;             // 1 = full load, 0 = address only
   logic        full_pend;             // full load waiting to start
   logic        mac_pend;              // address-only load waiting
   logic        ext_held;              // pin was seen asserted
   logic        programmed;            // last marker check passed
   // image storage
   logic [7:0]  img [0:IMG_DEPTH-1];   // header image 00h..13h
   logic [7:0]  wake_byte;             // power/wake flag byte
   // fetcher handshake
   logic        fetch_start;           // one-cycle fetch launch
   logic        fetch_done;            // fetched byte available
   logic [7:0]  fetch_data;            // fetched byte
   logic        soft_wr;               // soft reload request written
   // current fetch decode
   logic        sig_ok;                // fetched marker matches
   logic        at_sig;                // current fetch is the marker
   logic        last_byte;             // current fetch ends the load
   logic [7:0]  next_addr;             // address after the current one

   // byte fetcher toward the eeprom controller
   // one byte in flight at a time
   ee_byte_fetch u_fetch (
      .clk     (CLK),
      .rst_b   (RST_B),
      .ce      (CE),
      .start   (fetch_start),
      .addr    (cur_addr),
      .done    (fetch_done),
      .data    (fetch_data),
      .ee_req  (EE_REQ),
      .ee_ack  (EE_ACK),
      .ee_data (EE_DATA)
   );

   // launch, soft strobe, marker
   assign fetch_start = (state == S_ISSUE);
   assign soft_wr     = REG_WR && (REG_ADDR == REG_CTRL) && REG_WDATA[CTRL_SOFT_BIT];
   assign at_sig      = (cur_addr == SIG_ADDR);
   assign sig_ok      = (fetch_data == SIG_VALUE);

   // sequence of addresses: marker, header image, wake byte
   // address-only stops at 06h
   // full load jumps 13h to 20h
   always_comb begin
      // default: next byte
      next_addr = cur_addr + 8'h01;
      last_byte = 1'b0;
      if (!mode_full && cur_addr == MAC_LAST) begin
         last_byte = 1'b1;
      end else if (cur_addr == IMG_LAST) begin
         next_addr = WAKE_ADDR;
      end else if (cur_addr == WAKE_ADDR) begin
         last_byte = 1'b1;
      end
   end

   // pin assertion is remembered; the load starts once it is released
   // release edge also raises full_pend
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ext_held <= 1'b0;
      end else if (CE) begin
         if (!EXTERNAL_RESET_PIN_B) begin
            // pin low: arm
            ext_held <= 1'b1;
         end else begin
            // released: disarm
            ext_held <= 1'b0;
         end
      end
   end

   // full load request: after reset, pin release, or soft bit; set wins
   // set at reset: power-on load
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         full_pend <= 1'b1;
      end else if (CE) begin
         if (soft_wr || (ext_held && EXTERNAL_RESET_PIN_B)) begin
            full_pend <= 1'b1;
         end else if (state == S_IDLE && EXTERNAL_RESET_PIN_B) begin
            // taken while idle
            full_pend <= 1'b0;
         end
      end
   end

   // address-only request from a usb bus reset; set wins
   // waits here during a load
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         mac_pend <= 1'b0;
      end else if (CE) begin
         if (USB_BUS_RESET) begin
            mac_pend <= 1'b1;
         end else if (state == S_IDLE && EXTERNAL_RESET_PIN_B) begin
            // taken, or superseded
            mac_pend <= 1'b0;
         end
      end
   end

   // load sequencer
   // issue, ack wait, done cycle
   // bad marker ends the load
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state     <= S_IDLE;
         cur_addr  <= SIG_ADDR;
         mode_full <= 1'b1;
      end else if (CE) begin
         unique case (state)
            S_IDLE: begin
               // wait while the pin is asserted, then pick a request
               if (EXTERNAL_RESET_PIN_B && (full_pend || mac_pend)) begin
                  state     <= S_ISSUE;
                  cur_addr  <= SIG_ADDR;
                  mode_full <= full_pend;
               end
            end
            S_ISSUE: begin
               // fetch_start high here
               state <= S_WAIT;
            end
            S_WAIT: begin
               // wait for the byte
               if (fetch_done) begin
                  if (full_pend) begin
                     // a newer full load supersedes this one
                     state <= S_IDLE;
                  end else if ((at_sig && !sig_ok) || last_byte) begin
                     // blank or last byte
                     state <= S_IDLE;
                  end else begin
                     // next address
                     state    <= S_ISSUE;
                     cur_addr <= next_addr;
                  end
               end
            end
         endcase
      end
   end

   // marker result, kept for status
   // superseded loads keep it
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         programmed <= 1'b0;
      end else if (CE) begin
         if (state == S_WAIT && fetch_done && at_sig && !full_pend) begin
            programmed <= sig_ok;
         end
      end
   end

   // header image: fetched bytes or defaults
   // defaults stand from reset
   // superseded loads write nothing more
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < IMG_DEPTH; i++) begin
            img[i] <= default_byte(i);
         end
      end else if (CE) begin
         if (state == S_WAIT && fetch_done && !full_pend) begin
            // blank: defaults
            if (at_sig && !sig_ok) begin
               for (int i = 0; i < IMG_DEPTH; i++) begin
                  // address-only reload touches only address octets
                  if (mode_full || (i >= int'(MAC_FIRST) && i <= int'(MAC_LAST))) begin
                     img[i] <= default_byte(i);
                  end
               end
            end else if (!at_sig && cur_addr <= IMG_LAST) begin
               // store at offset
               img[cur_addr[4:0]] <= fetch_data;
            end
         end
      end
   end

   // wake flag byte: fetched in a full load, else default
   // untouched by address-only
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         wake_byte <= DEF_OTHER;
      end else if (CE) begin
         if (state == S_WAIT && fetch_done && !full_pend && mode_full) begin
            if (at_sig && !sig_ok) begin
               wake_byte <= DEF_OTHER;
            end else if (cur_addr == WAKE_ADDR) begin
               // final full-load byte
               wake_byte <= fetch_data;
            end
         end
      end
   end

   // decoded usb configuration
   // octet 01h on top
   always_comb begin
      USB_CFG.mac         = {img[1], img[2], img[3], img[4], img[5], img[6]};
      USB_CFG.fs_interval = img[FS_ADDR[4:0]];
      USB_CFG.hs_interval = img[HS_ADDR[4:0]];
      USB_CFG.cfg_flags0  = img[CFG0_ADDR[4:0]];
      USB_CFG.lang_id     = {img[LANG_HI[4:0]], img[LANG_LO[4:0]]};
   end

   // string descriptor pairs: length then word pointer
   // pair g at 0Ch + 2g
   // word pointer doubled
   genvar g;
   generate
      for (g = 0; g < STR_COUNT; g++) begin : g_str
         localparam int LEN_IDX = int'(STR_BASE) + 2 * g;
         assign STR_DESC[g].len       = img[LEN_IDX];
         assign STR_DESC[g].byte_addr = {img[LEN_IDX + 1], 1'b0};
      end
   endgenerate

   // wake decode; link-up selection masks the event enables
   // select bit passed raw
   always_comb begin
      WAKE_CFG.wake_source_select     = wake_byte[WAKE_SEL_BIT];
      WAKE_CFG.magic_wake_enable      = wake_byte[WAKE_MAGIC_BIT] && !wake_byte[WAKE_SEL_BIT];
      WAKE_CFG.dest_match_wake_enable = wake_byte[WAKE_DA_BIT] && !wake_byte[WAKE_SEL_BIT];
   end

   // ready only when no full load is running or waiting
   // address-only load
   // keeps ready high
   assign CONFIG_READY = !full_pend && !ext_held && EXTERNAL_RESET_PIN_B
                         && (state == S_IDLE || !mode_full);

   // register read port, data one cycle after the strobe
   // no read side effects
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         REG_RDATA <= 32'h0000_0000;
      end else if (CE) begin
         REG_RDATA <= 32'h0000_0000;
         if (REG_RD) begin
            // decode address
            unique case (REG_ADDR)
               REG_STATUS: begin
                  // low status bits
                  REG_RDATA[STAT_READY_BIT] <= CONFIG_READY;
                  REG_RDATA[STAT_PROG_BIT]  <= programmed;
                  REG_RDATA[STAT_BUSY_BIT]  <= (state != S_IDLE);
               end
               REG_MAC_HI: begin
                  // octets 01h..04h
                  REG_RDATA <= USB_CFG.mac[47:16];
               end
               REG_MAC_LO: begin
                  // octets 05h, 06h
                  REG_RDATA[15:0] <= USB_CFG.mac[15:0];
               end
               REG_WAKE: begin
                  // raw, not masked
                  REG_RDATA[7:0] <= wake_byte;
               end
               default: begin
                  // control reads zero; unmapped addresses read zero
                  REG_RDATA <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

endmodule // serial_eeprom_autoload
`default_nettype wire

// File: sim/eeprom_model.sv
`timescale 1ns/10ps
`default_nettype none
// byte-wide storage behind the fetch port, answering promptly or after a random stall
module eeprom_model (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // fetch port
   input  wire eeload_pkg::ee_req_t ee_req,
   output logic                     ee_ack,
   output logic [7:0]               ee_data
);
   import eeload_pkg::*;
   logic [7:0] mem [0:255];  // image contents, filled by the bench
   int         stall;        // cycles still to wait before answering

   // one-cycle acknowledge; data is scrambled whenever no answer stands
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ee_ack  <= 1'b0;
         ee_data <= 8'h5A;
         stall   <= 0;
      end else if (ee_req.req && !ee_ack) begin
         if (stall == 0) begin
            ee_ack  <= 1'b1;
            ee_data <= mem[ee_req.addr];
            stall   <= $urandom_range(0, 3);
         end else begin
            stall   <= stall - 1;
            ee_data <= ~ee_data;
         end
      end else begin
         ee_ack  <= 1'b0;
         ee_data <= ~ee_data;
      end
   end
endmodule // eeprom_model
`default_nettype wire

// File: sim/serial_eeprom_autoload_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the loader
module serial_eeprom_autoload_checker (
   // clock and reset
   input wire logic                                     CLK,
   input wire logic                                     RST_B,
   input wire logic                                     CE,
   // triggers
   input wire logic                                     USB_BUS_RESET,
   input wire logic                                     EXTERNAL_RESET_PIN_B,
   // register port
   input wire logic [7:0]                               REG_ADDR,
   input wire logic [31:0]                              REG_WDATA,
   input wire logic                                     REG_WR,
   input wire logic                                     REG_RD,
   input wire logic [31:0]                              REG_RDATA,
   // fetch port
   input wire eeload_pkg::ee_req_t                      EE_REQ,
   input wire logic                                     EE_ACK,
   input wire logic [7:0]                               EE_DATA,
   // consumers
   input wire eeload_pkg::usb_cfg_t                     USB_CFG,
   input wire eeload_pkg::str_desc_t [eeload_pkg::STR_COUNT-1:0] STR_DESC,
   input wire eeload_pkg::wake_cfg_t                    WAKE_CFG,
   input wire logic                                     CONFIG_READY
);
   import eeload_pkg::*;
   logic seen_req;  // a fetch has been issued since reset

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   // remembers the first fetch after reset
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) seen_req <= 1'b0;
      else if (EE_REQ.req) seen_req <= 1'b1;
   end

   sequence s_taken;
      CE && EE_REQ.req && EE_ACK;
   endsequence
   sequence s_gap;
      !EE_REQ.req [*2];
   endsequence

   AST_FIRST_ADDR: assert property (EE_REQ.req && !seen_req |-> EE_REQ.addr == SIG_ADDR)
      else $error("first fetch not at marker address");
   AST_REQ_HOLD: assert property (EE_REQ.req && !EE_ACK && EXTERNAL_RESET_PIN_B |=> EE_REQ.req && $stable(EE_REQ.addr))
      else $error("fetch request dropped or moved");
   AST_ACK_GAP: assert property (s_taken |=> s_gap)
      else $error("fetch spacing wrong");
   AST_WAKE_MAGIC: assert property (WAKE_CFG.magic_wake_enable |-> !WAKE_CFG.wake_source_select)
      else $error("magic wake on with link-up select");
   AST_WAKE_DA: assert property (WAKE_CFG.dest_match_wake_enable |-> !WAKE_CFG.wake_source_select)
      else $error("dest match wake on with link-up select");
   AST_PIN_READY: assert property (!EXTERNAL_RESET_PIN_B |-> !CONFIG_READY)
      else $error("ready while pin held");
   AST_SOFT_READY: assert property (CE && REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[0] |=> !CONFIG_READY)
      else $error("ready after soft reload");
   AST_RDATA_IDLE: assert property (CE && !REG_RD |=> REG_RDATA == 32'h0)
      else $error("read data outside read slot");
   AST_STATUS_READ: assert property (CE && REG_RD && REG_ADDR == REG_STATUS |=>
      REG_RDATA[STAT_READY_BIT] == $past(CONFIG_READY) && REG_RDATA[31:3] == 29'h0)
      else $error("status ready bit wrong");
   AST_MAC_READ: assert property (CE && REG_RD && REG_ADDR == REG_MAC_HI |=> REG_RDATA == $past(USB_CFG.mac[47:16]))
      else $error("station address read wrong");
   AST_STR_EVEN: assert property (!(STR_DESC[0].byte_addr[0] | STR_DESC[1].byte_addr[0]
      | STR_DESC[2].byte_addr[0] | STR_DESC[3].byte_addr[0]))
      else $error("odd descriptor byte address");
endmodule // serial_eeprom_autoload_checker
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import eeload_pkg::*;
   logic CLK, RST_B, CE, USB_BUS_RESET, EXTERNAL_RESET_PIN_B, REG_WR, REG_RD, EE_ACK, CONFIG_READY;
   logic [7:0] REG_ADDR, EE_DATA;
   logic [31:0] REG_WDATA, REG_RDATA;
   ee_req_t EE_REQ;
   usb_cfg_t USB_CFG;
   str_desc_t [STR_COUNT-1:0] STR_DESC;
   wake_cfg_t WAKE_CFG;
   int num_errors = 0;  // mismatches
   int checks = 0;      // comparisons made
   logic [31:0] d;
   logic [7:0] keep [7:9];

   serial_eeprom_autoload i_dut (.CLK(CLK), .RST_B(RST_B), .CE(CE), .USB_BUS_RESET(USB_BUS_RESET),
      .EXTERNAL_RESET_PIN_B(EXTERNAL_RESET_PIN_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EE_REQ(EE_REQ), .EE_ACK(EE_ACK),
      .EE_DATA(EE_DATA), .USB_CFG(USB_CFG), .STR_DESC(STR_DESC), .WAKE_CFG(WAKE_CFG),
      .CONFIG_READY(CONFIG_READY));
   eeprom_model i_ee (.clk(CLK), .rst_b(RST_B), .ee_req(EE_REQ), .ee_ack(EE_ACK), .ee_data(EE_DATA));

   // 50 MHz clock
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end

   task automatic conclude();
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // expected image byte: stored value or built-in default
   function automatic logic [7:0] eb(input int a, input bit prog);
      if (prog) return i_ee.mem[a];
      if (a >= 1 && a <= 6) return 8'hFF;
      case (a)
         7: return 8'h01;
         8: return 8'h04;
         9: return 8'h1B;
         default: return 8'h00;
      endcase
   endfunction

   // wake enables masked by the link-up selection
   function automatic wake_cfg_t exp_wake(input logic [7:0] b);
      return {b[2], b[1] & ~b[2], b[0] & ~b[2]};
   endfunction

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_WDATA <= v;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 v = REG_RDATA;
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      repeat (2) @(posedge CLK);
      while (CONFIG_READY !== 1'b1 && n < 3000) begin
         @(posedge CLK);
         n++;
      end
      if (n >= 3000) begin
         num_errors++;
         conclude();
      end
   endtask

   // programmed image with random contents and the given wake selection
   task automatic rand_image(input logic [2:0] w);
      i_ee.mem[0] = 8'hA5;
      for (int a = 1; a < 20; a++) i_ee.mem[a] = 8'($urandom);
      i_ee.mem[32] = {5'($urandom), w};
   endtask

   task automatic check_image(input bit prog);
      logic [31:0] v;
      logic [47:0] m;
      for (int i = 1; i <= 6; i++) m = {m[39:0], eb(i, prog)};
      check(USB_CFG.mac, m);
      check(USB_CFG.fs_interval, eb(7, prog));
      check(USB_CFG.hs_interval, eb(8, prog));
      check(USB_CFG.cfg_flags0, eb(9, prog));
      check(USB_CFG.lang_id, {eb(11, prog), eb(10, prog)});
      for (int i = 0; i < 4; i++) begin
         check(STR_DESC[i].len, eb(12 + 2 * i, prog));
         check(STR_DESC[i].byte_addr, {eb(13 + 2 * i, prog), 1'b0});
      end
      check(WAKE_CFG, exp_wake(eb(32, prog)));
      reg_rd(REG_STATUS, v);
      check(v, {29'h0, 1'b0, prog, 1'b1});
      reg_rd(REG_MAC_LO, v);
      check(v, {16'h0, m[15:0]});
      reg_rd(REG_WAKE, v);
      check(v, {24'h0, eb(32, prog)});
   endtask

   // watchdog
   initial begin
      repeat (60000) @(posedge CLK);
      num_errors++;
      conclude();
   end

   initial begin
      {RST_B, USB_BUS_RESET, REG_WR, REG_RD} = 4'h0;
      {CE, EXTERNAL_RESET_PIN_B} = 2'b11;
      REG_ADDR = 8'h00;
      REG_WDATA = 32'h0;
      void'($urandom(32'h6d3e));
      rand_image(3'b000);
      repeat (2) @(posedge CLK);
      RST_B <= 1'b1;
      wait_ready();
      check_image(1'b1);
      // soft reload through every wake selection
      for (int w = 0; w < 8; w++) begin
         rand_image(w[2:0]);
         reg_wr(REG_CTRL, 32'h1);
         if (w == 3) reg_wr(REG_CTRL, 32'h1);
         wait_ready();
         check_image(1'b1);
      end
      // writes elsewhere and unmapped reads are refused
      reg_wr(REG_WAKE, 32'h1);
      repeat (2) @(posedge CLK);
      check(CONFIG_READY, 1'b1);
      reg_rd(8'h3C, d);
      check(d, 32'h0);
      // usb bus reset refreshes the station address only
      for (int a = 7; a <= 9; a++) keep[a] = i_ee.mem[a];
      for (int a = 1; a <= 9; a++) i_ee.mem[a] = 8'($urandom);
      @(posedge CLK);
      USB_BUS_RESET <= 1'b1;
      @(posedge CLK);
      USB_BUS_RESET <= 1'b0;
      repeat (4) @(posedge CLK);
      check(CONFIG_READY, 1'b1);
      for (int n = 0; n < 500; n++) begin
         reg_rd(REG_STATUS, d);
         if (d[STAT_BUSY_BIT] === 1'b0) break;
      end
      check(d[STAT_BUSY_BIT], 1'b0);
      for (int a = 7; a <= 9; a++) i_ee.mem[a] = keep[a];
      check_image(1'b1);
      // blank marker falls back to defaults
      d = $urandom;
      i_ee.mem[0] = (d[7:0] == 8'hA5) ? 8'h00 : d[7:0];
      reg_wr(REG_CTRL, 32'h1);
      wait_ready();
      check_image(1'b0);
      // external pin holds the device off, release reloads
      rand_image(3'b101);
      @(posedge CLK);
      EXTERNAL_RESET_PIN_B <= 1'b0;
      CE <= 1'b0;
      repeat (3) @(posedge CLK);
      CE <= 1'b1;
      repeat (3) @(posedge CLK);
      check(CONFIG_READY, 1'b0);
      EXTERNAL_RESET_PIN_B <= 1'b1;
      wait_ready();
      check_image(1'b1);
      // mid-run reset: defaults at once, then a fresh load
      @(posedge CLK);
      RST_B <= 1'b0;
      repeat (2) @(posedge CLK);
      check(CONFIG_READY, 1'b0);
      check(USB_CFG.hs_interval, DEF_HS);
      RST_B <= 1'b1;
      wait_ready();
      check_image(1'b1);
      conclude();
   end
endmodule // testbench

bind serial_eeprom_autoload serial_eeprom_autoload_checker i_chk (.CLK(CLK), .RST_B(RST_B), .CE(CE),
   .USB_BUS_RESET(USB_BUS_RESET), .EXTERNAL_RESET_PIN_B(EXTERNAL_RESET_PIN_B), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EE_REQ(EE_REQ),
   .EE_ACK(EE_ACK), .EE_DATA(EE_DATA), .USB_CFG(USB_CFG), .STR_DESC(STR_DESC), .WAKE_CFG(WAKE_CFG),
   .CONFIG_READY(CONFIG_READY));
`default_nettype wire
